//--- hw/nfs_pkg.sv
// Package: constants for the NAND flash command sequencer controller.
// Behaviour
// R01: Copy-back read 35h buffers page internally.
// R02: After ready, send 85h, address, 10h.
// R03: Keep plane select bit equal on copy.
// R04: No partial program on copied pages.
// R05: Device accepts data overwrite before confirm.
// R06: Copy-back failure shows in pass/fail bit.
// R07: Two-bit ECC recommended with copy-back; the sequencer applies none and leaves it to software.
// R08: Erase is 60h, three addresses, D0h.
// R09: Device ignores page bits on erase.
// R10: Erase starts on confirm; result bit 0.
// R11: Status read 70h drives status register.
// R12: Reissue 00h after status during read.
// R13: Status bits: fail, cache fail, ready, protect.
// R14: Mask unused status bits when interpreting.
// R15: ID 90h, address 00h, five bytes.
// R16: Reset FFh aborts, status becomes C0h.
// R17: Reset accepted while already resetting.
// R18: Busy low for reset time after FFh.
// R19: Power-up mode depends on auto-read pin.
// R20: Auto-read first page at power-on.
// R21: Busy low during program, erase, read.
// R22: Wait recovery time after power-up; hold protect.
package nfs_pkg;
	// Flash commands.
	localparam logic [7:0] CMD_READ = 8'h00;
	localparam logic [7:0] CMD_READ_GO = 8'h30;
	localparam logic [7:0] CMD_COPY_READ = 8'h35;
	localparam logic [7:0] CMD_COPY_IN = 8'h85;
	localparam logic [7:0] CMD_PROG_GO = 8'h10;
	localparam logic [7:0] CMD_ERASE = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_ID = 8'h90;
	localparam logic [7:0] CMD_RESET = 8'hFF;
	localparam logic [7:0] STATUS_AFTER_RESET = 8'hC0;
	// Status bit positions.
	localparam int ST_FAIL = 0;
	localparam int ST_CACHE_FAIL = 1;
	localparam int ST_TRUE_RDY = 5;
	localparam int ST_RDY = 6;
	localparam int ST_WP_N = 7;
	localparam logic [7:0] ST_USED_MASK = 8'hE3;
	// Register byte offsets.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR_LO = 8'h04;
	localparam logic [7:0] REG_ADDR_HI = 8'h08;
	localparam logic [7:0] REG_WDATA = 8'h0C;
	localparam logic [7:0] REG_STAT = 8'h10;
	localparam logic [7:0] REG_RDATA = 8'h14;
	localparam logic [7:0] REG_DEVSTAT = 8'h18;
	localparam logic [7:0] REG_ID0 = 8'h1C;
	localparam logic [7:0] REG_ID1 = 8'h20;
	// Control fields.
	localparam int CTRL_GO = 0;
	localparam int CTRL_OP_LSB = 1;
	localparam int CTRL_WP_N = 8;
	localparam int CTRL_LEN_LSB = 16;
	// Timing.
	localparam int CLK_NS = 50;
	localparam int T_RECOVERY_US = 10;
	localparam int RECOVERY_CYC = (T_RECOVERY_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int T_STROBE_NS = 50;
	localparam int STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int STROBE_W = 4;
	localparam int ID_BYTES = 5;
	// Operations.
	typedef enum logic [2:0] {
		nfs_op_reset_t_dummy = 3'b111
	} nfs_dummy_t;
	localparam logic [2:0] OP_RESET = 3'b000;
	localparam logic [2:0] OP_STATUS = 3'b001;
	localparam logic [2:0] OP_ID = 3'b010;
	localparam logic [2:0] OP_ERASE = 3'b011;
	localparam logic [2:0] OP_COPY = 3'b100;
	localparam logic [2:0] OP_READ = 3'b101;
endpackage

//--- hw/nfs_strobe.sv
// Module: one flash bus cycle, command, address, data write or data read.
`timescale 1ns/1ps
module nfs_strobe #(
	parameter int HOLD = nfs_pkg::STROBE_CYC
) (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// Request.
	input wire logic start,
	input wire logic is_read,
	output logic done,
	// Strobe pins.
	output logic write_strobe_n,
	output logic read_strobe_n
);
	logic [nfs_pkg::STROBE_W-1:0] cnt;
	logic low_phase;
	logic high_phase;
	localparam logic [nfs_pkg::STROBE_W-1:0] LAST =
		nfs_pkg::STROBE_W'(HOLD - 1);
	// Strobe low for HOLD cycles then high for HOLD cycles; pins registered.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= '0;
			low_phase <= 1'b0;
			high_phase <= 1'b0;
			write_strobe_n <= 1'b1;
			read_strobe_n <= 1'b1;
		end else if (ce) begin
			if (start && !low_phase && !high_phase) begin
				low_phase <= 1'b1;
				cnt <= '0;
				write_strobe_n <= is_read;
				read_strobe_n <= !is_read;
			end else if (low_phase && cnt == LAST) begin
				low_phase <= 1'b0;
				high_phase <= 1'b1;
				cnt <= '0;
				write_strobe_n <= 1'b1;
				read_strobe_n <= 1'b1;
			end else if (high_phase && cnt == LAST) begin
				high_phase <= 1'b0;
			end else if (low_phase || high_phase) begin
				cnt <= cnt + 1'b1;
			end
		end
	end
	// Done pulses in the last high cycle; read data is caught earlier.
	assign done = ce && high_phase && cnt == LAST;
endmodule

//--- hw/nfs_ctrl.sv
// Module: AHB-Lite controlled sequencer driving a NAND flash device.
`timescale 1ns/1ps
module nfs_ctrl #(
	parameter int RECOVERY = nfs_pkg::RECOVERY_CYC
) (
	// Clock, reset and enable.
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Flash pins.
	output logic chip_enable_n,
	output logic cmd_latch,
	output logic addr_latch,
	output logic write_strobe_n,
	output logic read_strobe_n,
	output logic write_protect_n,
	output logic [7:0] io_out,
	output logic io_oe,
	input wire logic [7:0] io_in,
	input wire logic ready_busy_n
);
	typedef enum logic [3:0] {
		S_POWER = 4'b0000,
		S_IDLE = 4'b0001,
		S_CMD = 4'b0010,
		S_ADDR = 4'b0011,
		S_WAIT = 4'b0100,
		S_CMD2 = 4'b0101,
		S_ADDR2 = 4'b0110,
		S_DATA = 4'b0111,
		S_CMD3 = 4'b1000,
		S_READ = 4'b1001,
		S_BUSY = 4'b1010
	} nfs_state_t;
	nfs_state_t state;
	logic [13:0] rec_cnt;
	logic [2:0] op;
	logic [2:0] idx;
	logic [39:0] addr;
	logic [39:0] addr2;
	logic [7:0] wdata;
	logic [7:0] len;
	logic [7:0] status;
	logic [7:0] rdata;
	logic [39:0] id;
	logic wp_n;
	logic done_flag;
	logic fail_flag;
	logic plane_err;
	logic st_start;
	logic st_read;
	logic st_done;
	// Bus address phase registers.
	logic ph_wr;
	logic ph_rd;
	logic [7:0] ph_addr;
	wire bus_go = hsel && hready && htrans[1];
	wire wr_ctrl = ph_wr && ph_addr == nfs_pkg::REG_CTRL;
	wire busy = state != S_IDLE;
	wire go = wr_ctrl && hwdata[nfs_pkg::CTRL_GO] && !busy;
	wire [2:0] go_op = hwdata[nfs_pkg::CTRL_OP_LSB +: 3];
	// Copy stays within one plane: compare the plane select bit.
	// The target's bit 28 sits in addr2[12], as dest takes addr2 above 16.
	wire plane_select_address_bit_diff = addr[28] != addr2[12]; // R03
	wire rd_cycle = state == S_READ;
	wire last_addr_e = idx == 3'd2;
	wire last_addr_5 = idx == 3'd4;
	wire erase_op = op == nfs_pkg::OP_ERASE;
	wire addr_last = erase_op ? last_addr_e : last_addr_5;

	nfs_strobe u_strobe (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(clk_en),
		.start(st_start),
		.is_read(st_read),
		.done(st_done),
		.write_strobe_n(write_strobe_n),
		.read_strobe_n(read_strobe_n)
	);

	////////////////////////////////////////////////////////////////////
	// Bus slave always answers at once with OKAY.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_wr <= 1'b0;
			ph_rd <= 1'b0;
			ph_addr <= 8'h00;
		end else if (clk_en) begin
			ph_wr <= bus_go && hwrite;
			ph_rd <= bus_go && !hwrite;
			ph_addr <= haddr;
		end
	end
	// Read mux; unmapped words read as zero.
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (ph_addr == nfs_pkg::REG_CTRL) begin
			rd_mux = {8'h00, len, 7'h00, wp_n, 4'h0, op, 1'b0};
		end else if (ph_addr == nfs_pkg::REG_ADDR_LO) begin
			rd_mux = addr[31:0];
		end else if (ph_addr == nfs_pkg::REG_ADDR_HI) begin
			rd_mux = {addr2[23:0], addr[39:32]};
		end else if (ph_addr == nfs_pkg::REG_WDATA) begin
			rd_mux = {24'h0, wdata};
		end else if (ph_addr == nfs_pkg::REG_STAT) begin
			rd_mux = {28'h0, plane_err, fail_flag, done_flag, busy};
		end else if (ph_addr == nfs_pkg::REG_RDATA) begin
			rd_mux = {24'h0, rdata};
		end else if (ph_addr == nfs_pkg::REG_DEVSTAT) begin
			rd_mux = {24'h0, status};
		end else if (ph_addr == nfs_pkg::REG_ID0) begin
			rd_mux = id[31:0];
		end else if (ph_addr == nfs_pkg::REG_ID1) begin
			rd_mux = {24'h0, id[39:32]};
		end
	end
	assign hrdata = rd_mux;
	// Flash read byte is caught while read strobe is low; once the strobe
	// rises the device may let go of the bus, so done comes too late.
	logic [7:0] rd_hold;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_hold <= 8'h00;
		end else if (clk_en && !read_strobe_n) begin
			rd_hold <= io_in;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Configuration registers; writes ignored while an operation runs.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr <= '0;
			addr2 <= '0;
			wdata <= 8'h00;
			len <= 8'h00;
			wp_n <= 1'b0; // R22
		end else if (clk_en && ph_wr && !busy) begin
			if (ph_addr == nfs_pkg::REG_ADDR_LO) begin
				addr[31:0] <= hwdata;
			end else if (ph_addr == nfs_pkg::REG_ADDR_HI) begin
				addr[39:32] <= hwdata[7:0];
				addr2[23:0] <= hwdata[31:8];
			end else if (ph_addr == nfs_pkg::REG_WDATA) begin
				wdata <= hwdata[7:0];
			end else if (ph_addr == nfs_pkg::REG_CTRL) begin
				wp_n <= hwdata[nfs_pkg::CTRL_WP_N];
				len <= hwdata[nfs_pkg::CTRL_LEN_LSB +: 8];
			end
		end
	end
	assign write_protect_n = wp_n;
	// Destination low bytes reuse source low bytes; upper bytes come from addr2.
	wire [39:0] dest = {addr2[23:0], addr[15:0]};

	////////////////////////////////////////////////////////////////////
	// Pin values for the current flash cycle.
	logic [7:0] cmd_byte;
	logic [7:0] addr_byte;
	always_comb begin
		cmd_byte = nfs_pkg::CMD_RESET; // R16 R17
		case (op)
			nfs_pkg::OP_STATUS: cmd_byte = nfs_pkg::CMD_STATUS; // R11
			nfs_pkg::OP_ID: cmd_byte = nfs_pkg::CMD_ID; // R15
			nfs_pkg::OP_ERASE: cmd_byte = nfs_pkg::CMD_ERASE; // R08
			nfs_pkg::OP_COPY: cmd_byte = nfs_pkg::CMD_READ; // R01
			nfs_pkg::OP_READ: cmd_byte = nfs_pkg::CMD_READ; // R12
			default: cmd_byte = nfs_pkg::CMD_RESET;
		endcase
	end
	// Erase sends only the three row bytes; ID sends a single zero.
	wire [39:0] aw = state == S_ADDR2 ? dest :
		(erase_op ? {16'h0000, addr[39:16]} : addr); // R08
	assign addr_byte = op == nfs_pkg::OP_ID ? 8'h00 : aw[idx*8 +: 8];
	wire [7:0] cmd2 = erase_op ? nfs_pkg::CMD_ERASE_GO :
		(op == nfs_pkg::OP_COPY ? nfs_pkg::CMD_COPY_READ :
		nfs_pkg::CMD_READ_GO);
	wire [7:0] cur_cmd = state == S_CMD ? cmd_byte :
		state == S_CMD2 ? (op == nfs_pkg::OP_COPY && idx == 3'd7 ?
		nfs_pkg::CMD_COPY_IN : cmd2) : nfs_pkg::CMD_PROG_GO; // R02
	always_comb begin
		cmd_latch = state == S_CMD || state == S_CMD2 || state == S_CMD3;
		addr_latch = state == S_ADDR || state == S_ADDR2;
		io_oe = busy && state != S_POWER && state != S_READ &&
			state != S_WAIT && state != S_BUSY;
		io_out = cmd_latch ? cur_cmd : (addr_latch ? addr_byte : wdata);
		chip_enable_n = !busy || state == S_POWER;
		st_start = io_oe || rd_cycle;
		st_read = rd_cycle;
	end

	////////////////////////////////////////////////////////////////////
	// Sequencer. The copy path uses idx 7 as a flag for its second half.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= S_POWER;
			rec_cnt <= '0;
			op <= nfs_pkg::OP_RESET;
			idx <= 3'd0;
			status <= nfs_pkg::STATUS_AFTER_RESET;
			rdata <= 8'h00;
			id <= '0;
			done_flag <= 1'b0;
			fail_flag <= 1'b0;
			plane_err <= 1'b0;
		end else if (clk_en) begin
			if (wr_ctrl && hwdata[nfs_pkg::CTRL_GO + 3]) begin
				done_flag <= 1'b0;
			end
			case (state)
				S_POWER: begin
					rec_cnt <= rec_cnt + 1'b1;
					if (rec_cnt == 14'(RECOVERY - 1)) begin
						state <= S_IDLE; // R22
					end
				end
				S_IDLE: begin
					if (go && go_op == nfs_pkg::OP_COPY &&
						plane_select_address_bit_diff) begin
						plane_err <= 1'b1; // R03
					end else if (go) begin
						op <= go_op;
						idx <= 3'd0;
						plane_err <= 1'b0;
						state <= S_CMD;
					end
				end
				S_CMD: if (st_done) begin
					idx <= 3'd0;
					if (op == nfs_pkg::OP_RESET) begin
						state <= S_WAIT; // R18
					end else if (op == nfs_pkg::OP_STATUS) begin
						state <= S_READ;
					end else begin
						state <= S_ADDR;
					end
				end
				S_ADDR: if (st_done) begin
					idx <= idx + 1'b1;
					if (op == nfs_pkg::OP_ID) begin
						idx <= 3'd0;
						state <= S_READ; // R15
					end else if (addr_last) begin
						state <= S_CMD2;
					end
				end
				S_CMD2: if (st_done) begin
					if (idx == 3'd7) begin
						idx <= 3'd0;
						state <= S_ADDR2;
					end else begin
						state <= S_WAIT; // R10 R21
					end
				end
				S_WAIT: if (ready_busy_n && st_done == 1'b0) begin
					if (op == nfs_pkg::OP_COPY && idx != 3'd7) begin
						idx <= 3'd7;
						state <= S_CMD2; // R02
					end else if (op == nfs_pkg::OP_RESET) begin
						status <= nfs_pkg::STATUS_AFTER_RESET; // R16
						state <= S_IDLE;
						done_flag <= 1'b1;
					end else if (op == nfs_pkg::OP_READ) begin
						idx <= 3'd0;
						state <= S_READ;
					end else begin
						op <= nfs_pkg::OP_STATUS; // R06 R10
						state <= S_CMD;
					end
				end
				S_ADDR2: if (st_done) begin
					idx <= idx + 1'b1;
					if (last_addr_5) begin
						state <= len != 8'h00 ? S_DATA : S_CMD3;
						idx <= 3'd0;
					end
				end
				S_DATA: if (st_done) begin
					idx <= idx + 1'b1; // R05
					if (idx == len[2:0] - 3'd1) begin
						state <= S_CMD3;
					end
				end
				// After the confirm only a status read follows, so copied
				// pages never get a further partial program.
				S_CMD3: if (st_done) begin
					idx <= 3'd7; // R04
					state <= S_WAIT;
				end
				// Bytes go out raw; error correction is left to software.
				S_READ: if (st_done) begin
					rdata <= rd_hold; // R07
					idx <= idx + 1'b1;
					if (op == nfs_pkg::OP_STATUS) begin
						status <= rd_hold;
						fail_flag <= rd_hold[nfs_pkg::ST_FAIL]; // R13 R14
						state <= S_IDLE;
						done_flag <= 1'b1;
					end else if (op == nfs_pkg::OP_ID) begin
						id[idx*8 +: 8] <= rd_hold;
						if (idx == 3'(nfs_pkg::ID_BYTES - 1)) begin
							state <= S_IDLE;
							done_flag <= 1'b1;
						end
					end else begin
						state <= S_IDLE;
						done_flag <= 1'b1;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end
endmodule

//--- tb/nfs_ctrl_monitor.sv
// Checker that watches the sequencer's ports.
`timescale 1ns/1ps
module nfs_ctrl_monitor #(
	parameter int RECOVERY = nfs_pkg::RECOVERY_CYC
) (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Bus side.
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	// Flash side.
	input wire logic chip_enable_n,
	input wire logic cmd_latch,
	input wire logic addr_latch,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic write_protect_n,
	input wire logic io_oe,
	input wire logic ready_busy_n
);
	int rec;
	// Cycles since reset release; the flash needs time to wake up first.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) rec <= 0;
		else if (rec < RECOVERY) rec <= rec + 1;
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////////////////////////////////////
	property p_ok; hreadyout && !hresp; endproperty
	a_ok: assert property (p_ok) else $error("bus stalled or erred");
	property p_ws; $fell(write_strobe_n) |=> write_strobe_n; endproperty
	a_ws: assert property (p_ws) else $error("write strobe too long");
	property p_rs; $fell(read_strobe_n) |=> read_strobe_n; endproperty
	a_rs: assert property (p_rs) else $error("read strobe too long");
	property p_rd; !read_strobe_n |-> !io_oe && write_strobe_n; endproperty
	a_rd: assert property (p_rd) else $error("bus driven in read");
	property p_wd; !write_strobe_n |-> io_oe && !chip_enable_n &&
		!(cmd_latch && addr_latch); endproperty
	a_wd: assert property (p_wd) else $error("bad write cycle");
	property p_bz; !ready_busy_n && !$past(ready_busy_n) |-> write_strobe_n;
	endproperty
	a_bz: assert property (p_bz) else $error("write while busy");
	property p_rc; rec < RECOVERY |-> chip_enable_n && write_strobe_n;
	endproperty
	a_rc: assert property (p_rc) else $error("flash used too early");
	property p_wp; hsel && hready && htrans[1] && hwrite && haddr == 8'h00
		|=> ##1 write_protect_n == $past(hwdata[8]); endproperty
	a_wp: assert property (p_wp) else $error("protect pin wrong");
endmodule
bind nfs_ctrl nfs_ctrl_monitor #(.RECOVERY(RECOVERY)) u_mon (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .chip_enable_n(chip_enable_n),
	.cmd_latch(cmd_latch), .addr_latch(addr_latch),
	.write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
	.write_protect_n(write_protect_n), .io_oe(io_oe),
	.ready_busy_n(ready_busy_n));

//--- tb/nfs_flash_model.sv
// Behavioural model of the flash device at the far side.
`timescale 1ns/1ps
module nfs_flash_model #(
	parameter logic [7:0] ID_MAKER = 8'h5A, // Arbitrary value.
	parameter logic [7:0] ID_DEV = 8'h3B, // Arbitrary value.
	parameter logic [7:0] ID_4 = 8'h21, // Arbitrary value.
	parameter logic [7:0] ID_5 = 8'h46 // Arbitrary value.
) (
	// Pins.
	input wire logic hclk,
	input wire logic chip_enable_n,
	input wire logic cmd_latch,
	input wire logic addr_latch,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic write_protect_n,
	input wire logic [7:0] io_out,
	output logic [7:0] io_in,
	output logic ready_busy_n,
	// Bench knobs: long busy times and a failing operation.
	input wire logic slow,
	input wire logic fail_req
);
	logic [39:0] adr;
	logic [1:0] mode;
	logic [2:0] idx;
	logic fail;
	logic [7:0] dcnt, last, q;
	int busy;
	// Power-up leaves the read command latched.
	initial begin
		adr = 0; mode = 0; idx = 0; fail = 0; dcnt = 0; last = 0; busy = 0;
		ready_busy_n = 1'b1;
	end
	task go_busy;
		busy = slow ? 60 : 3;
		ready_busy_n = 1'b0;
	endtask
	// Commands, address bytes and data bytes latch on the write strobe rise.
	always @(posedge write_strobe_n) if (!chip_enable_n) begin
		if (cmd_latch) begin
			case (io_out)
				8'hFF: begin mode = 0; fail = 0; go_busy(); end
				8'h70: mode = 1;
				8'h90: begin mode = 2; idx = 0; end
				8'h00: mode = 0;
				8'h30, 8'h35: go_busy();
				8'h85: dcnt = 0;
				8'h10, 8'hD0: begin fail = fail_req; go_busy(); end
				default: ;
			endcase
		end else if (addr_latch) adr = {io_out, adr[39:8]};
		else dcnt = dcnt + 1;
	end
	// Busy time runs on the bench clock; the pull-up restores the line.
	always @(posedge hclk) if (busy > 0) begin
		busy = busy - 1;
		if (busy == 0) ready_busy_n = 1'b1;
	end
	// Status bits 4:2 are don't care, so they carry junk on purpose.
	always @* begin
		case (mode)
			2'd0: q = adr[23:16] ^ adr[7:0] ^ 8'h3C;
			2'd1: q = {write_protect_n, ready_busy_n, ready_busy_n, 3'b101,
				1'b0, fail};
			default: q = idx == 0 ? ID_MAKER : idx == 1 ? ID_DEV :
				idx == 2 ? 8'hA5 : idx == 3 ? ID_4 : ID_5;
		endcase
	end
	// A released bus shows the inverse of the last byte, never a held value.
	assign io_in = (!chip_enable_n && !read_strobe_n) ? q : ~last;
	always @(posedge read_strobe_n) begin
		last = q;
		if (mode == 2) idx = idx + 1;
	end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the flash command sequencer.
`timescale 1ns/1ps
module testbench;
	logic hclk = 0, hresetn = 0, clk_en = 1, hsel = 0, hwrite = 0;
	logic [7:0] haddr = 0, io_out, io_in;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 0, hrdata, r, a, b;
	logic hready, hreadyout, hresp, chip_enable_n, cmd_latch, addr_latch;
	logic write_strobe_n, read_strobe_n, write_protect_n, io_oe;
	logic ready_busy_n, slow = 0, fail_req = 0;
	int fails = 0, n_tests = 0, seed = 32;
	assign hready = hreadyout;
	always #25 hclk = ~hclk;
	nfs_ctrl #(.RECOVERY(4)) u_dut (.hclk(hclk), .hresetn(hresetn),
		.clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.chip_enable_n(chip_enable_n), .cmd_latch(cmd_latch),
		.addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
		.read_strobe_n(read_strobe_n), .write_protect_n(write_protect_n),
		.io_out(io_out), .io_oe(io_oe), .io_in(io_in),
		.ready_busy_n(ready_busy_n));
	nfs_flash_model u_flash (.hclk(hclk), .chip_enable_n(chip_enable_n),
		.cmd_latch(cmd_latch), .addr_latch(addr_latch),
		.write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
		.write_protect_n(write_protect_n), .io_out(io_out), .io_in(io_in),
		.ready_busy_n(ready_busy_n), .slow(slow), .fail_req(fail_req));
	////////////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One single transfer; waits on hready in both phases.
	task bus(input logic w, input logic [7:0] ad, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1; haddr <= ad; hwrite <= w; htrans <= 2'b10;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00; hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task wait_idle;
		r = 32'h1;
		while (r[0] !== 1'b0) bus(1'b0, 8'h10, 32'h0, r);
	endtask
	task op(input logic [2:0] o, input logic wp, input logic [7:0] len);
		bus(1'b1, 8'h00, {8'h00, len, 7'h00, wp, 4'h0, o, 1'b1}, r);
		wait_idle();
	endtask
	task tally_and_finish;
		$display("Counts: %0d checks, %0d mismatches", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// The slowest flow is under a few hundred cycles; this span, 60000 cycles, is far beyond.
	initial begin
		#3000000;
		fails++;
		$display("Error watchdog expected done seen hang");
		tally_and_finish();
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, 8'h18, 32'h0, r);
		chk("devstat", 32'hC0, r);
		wait_idle();
		bus(1'b1, 8'h40, 32'h1234, r);
		bus(1'b0, 8'h40, 32'h0, r);
		// A reset then a status read, once under each protect level.
		for (int w = 0; w < 2; w++) begin
			op(3'd0, w[0], 8'h0);
			op(3'd1, w[0], 8'h0);
			bus(1'b0, 8'h18, 32'h0, r);
			chk("status", {24'h0, w[0], 7'h60}, r & 32'hE3);
		end
		$display("test reset_status done");
		op(3'd2, 1'b1, 8'h0);
		bus(1'b0, 8'h1C, 32'h0, r);
		chk("id0", {u_flash.ID_4, 8'h00, u_flash.ID_DEV, u_flash.ID_MAKER},
			r & 32'hFF00FFFF);
		bus(1'b0, 8'h20, 32'h0, r);
		chk("id1", {24'h0, u_flash.ID_5}, r & 32'hFF);
		$display("test id done");
		for (int i = 0; i < 4; i++) begin
			a = $random(seed);
			b = $random(seed);
			slow <= i[0];
			fail_req <= i[1];
			bus(1'b1, 8'h04, a, r);
			bus(1'b1, 8'h08, b, r);
			op(3'd3, 1'b1, 8'h0);
			chk("erase row", {8'h0, b[7:0], a[31:16]}, {8'h0, u_flash.adr[39:16]});
			bus(1'b0, 8'h18, 32'h0, r);
			chk("erase status", {24'h0, 7'h70, i[1]}, r & 32'hE3);
		end
		$display("test erase done");
		// Last pass puts source and target in different planes.
		for (int i = 0; i < 3; i++) begin
			a = $random(seed);
			b = $random(seed);
			b[20] = (i == 2) ? ~a[28] : a[28];
			fail_req <= i[0];
			bus(1'b1, 8'h04, a, r);
			bus(1'b1, 8'h08, b, r);
			bus(1'b1, 8'h0C, $random(seed), r);
			op(3'd4, 1'b1, 8'(i + 2));
			bus(1'b0, 8'h10, 32'h0, r);
			chk("plane error", {31'h0, i == 2}, {31'h0, r[3]});
			if (i < 2) begin
				chk("copy dest", {b[23:8], a[15:0]}, u_flash.adr[31:0]);
				chk("copy bytes", 32'(i + 2), {24'h0, u_flash.dcnt});
				bus(1'b0, 8'h18, 32'h0, r);
				chk("copy status", {31'h0, i[0]}, r & 32'h1);
			end
		end
		$display("test copy done");
		// A status read between two reads must not leak into the data.
		for (int i = 0; i < 2; i++) begin
			a = $random(seed);
			bus(1'b1, 8'h04, a, r);
			op(3'd5, 1'b1, 8'h0);
			bus(1'b0, 8'h14, 32'h0, r);
			chk("read byte", {24'h0, a[23:16] ^ a[7:0] ^ 8'h3C}, r & 32'hFF);
			op(3'd1, 1'b1, 8'h0);
		end
		$display("test read done");
		tally_and_finish();
	end
endmodule
